// ==== rtl/dtpal_pkg.sv ====
// Shared types and constants of the display timing and palette block
package dtpal_pkg;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [5:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } dtpal_wb_req_s;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } dtpal_wb_rsp_s;

  typedef struct packed {
    logic        hsync;
    logic        vsync;
    logic        de;
    logic        pix_req;
    logic        power;
    logic [15:0] pixel;
  } dtpal_vid_s;

  // Register byte offsets
  localparam logic [5:0] OFS_HEIGHT = 6'h00;
  localparam logic [5:0] OFS_ACT    = 6'h04;
  localparam logic [5:0] OFS_HSYNC  = 6'h08;
  localparam logic [5:0] OFS_VSYNC  = 6'h0c;
  localparam logic [5:0] OFS_BLANK  = 6'h10;
  localparam logic [5:0] OFS_PCTL   = 6'h14;
  localparam logic [5:0] OFS_WDATA  = 6'h18;
  localparam logic [5:0] OFS_RDATA  = 6'h1c;
  localparam logic [5:0] OFS_WIDTH  = 6'h20;
  localparam logic [5:0] OFS_CFG    = 6'h24;

  // Palette control fields
  localparam int PC_EN   = 15;
  localparam int PC_BUSY = 14;
  localparam int PC_TRIG = 9;
  localparam int PC_HOST = 8;

  // Configuration fields
  localparam int CF_HSOE = 0;
  localparam int CF_VSOE = 1;
  localparam int CF_PWR  = 2;
  localparam logic [15:0] CFG_MASK = 16'hc077;

  localparam logic [15:0] RST_REG16    = 16'h0000;
  localparam logic [1:0]  PAL_BUSY_CYC = 2'h2;
  localparam int          PAL_DEPTH    = 256;

endpackage

// ==== rtl/dtpal_mem.sv ====
// Palette table held in flip-flops, one write and one read port
`timescale 1ns/1ps
module dtpal_mem (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Write port
  input  wire logic        we,
  input  wire logic [7:0]  waddr,
  input  wire logic [15:0] wdata,
  // Read port
  input  wire logic [7:0]  raddr,
  output logic      [15:0] rdata
);
  import dtpal_pkg::*;

  typedef struct packed {
    logic [PAL_DEPTH-1:0][15:0] ent;
    logic [15:0]                rd;
  } dtpal_mem_s;

  dtpal_mem_s st_q, st_d;

  always_comb begin
    st_d = st_q;
    if (we) begin
      st_d.ent[waddr] = wdata;
    end
    st_d.rd = st_q.ent[raddr];
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata = st_q.rd;

endmodule

// ==== rtl/dtpal_axis.sv ====
// One timing axis: position counter with sync and active windows
`timescale 1ns/1ps
module dtpal_axis (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Step and settings
  input  wire logic        adv,
  input  wire logic [10:0] total,
  input  wire logic [7:0]  sync_start,
  input  wire logic [7:0]  sync_width,
  input  wire logic [7:0]  act_off,
  input  wire logic [7:0]  show_off,
  // Decoded position
  output logic      [10:0] pos,
  output logic             wrap,
  output logic             sync,
  output logic             fetch,
  output logic             shown
);
  import dtpal_pkg::*;

  typedef struct packed {
    logic [10:0] pos;
  } dtpal_axis_s;

  dtpal_axis_s st_q, st_d;
  logic [11:0] sync_end;

  always_comb begin
    // Position 0 is the start of blanking
    wrap = adv && ((total == 11'h000) ||
                   (st_q.pos >= total - 11'h001));
    sync_end = {4'h0, sync_start} + {4'h0, sync_width};
    sync  = ({1'b0, st_q.pos} >= {4'h0, sync_start}) &&
            ({1'b0, st_q.pos} < sync_end);
    fetch = st_q.pos >= {3'h0, act_off};
    shown = st_q.pos >= {3'h0, show_off};
    st_d = st_q;
    if (adv) begin
      st_d.pos = wrap ? 11'h000 : st_q.pos + 11'h001;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign pos = st_q.pos;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_wrap;
    wrap |=> st_q.pos == 11'h000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("axis did not wrap");

  property p_sync_start;
    (st_q.pos == {3'h0, sync_start}) && (sync_width != 8'h00) |-> sync;
  endproperty
  a_sync_start: assert property (p_sync_start)
    else $error("sync not active at start delay");

endmodule

// ==== rtl/dtpal_top.sv ====
// Display timing generator with palette access over Wishbone
`timescale 1ns/1ps
module dtpal_top (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rstn,
  // Wishbone slave
  input  wire dtpal_pkg::dtpal_wb_req_s wb_req,
  output      dtpal_pkg::dtpal_wb_rsp_s wb_rsp,
  // Pixel source
  input  wire logic [15:0]              pix_in,
  // Panel
  output      dtpal_pkg::dtpal_vid_s    vid
);
  import dtpal_pkg::*;

  typedef struct packed {
    logic [10:0] height;
    logic [15:0] act;
    logic [15:0] hs;
    logic [15:0] vs;
    logic [15:0] bl;
    logic        pal_en;
    logic        trig;
    logic        host;
    logic [7:0]  paddr;
    logic [15:0] wr;
    logic [15:0] rd;
    logic [10:0] width;
    logic [15:0] cfg;
    logic        ack;
    logic [31:0] dat;
    logic        busy;
    logic        op_wr;
    logic [1:0]  cnt;
    logic [7:0]  op_addr;
    logic [15:0] op_data;
    logic [15:0] pwr_cnt;
    logic [15:0] raw1;
    logic [1:0]  show;
    logic [1:0]  hs_p;
    logic [1:0]  vs_p;
    dtpal_vid_s  vid;
  } dtpal_top_s;

  dtpal_top_s  st_q, st_d;
  logic [10:0] h_pos;
  logic [10:0] v_pos;
  logic        h_wrap;
  logic        h_sync;
  logic        h_fetch;
  logic        h_show;
  logic        v_sync;
  logic        v_fetch;
  logic        v_show;
  logic        mem_we;
  logic [7:0]  mem_raddr;
  logic [15:0] mem_rd;
  logic        acc;
  logic        wr_acc;
  logic [5:0]  adr;
  logic [15:0] rdv;
  logic [15:0] nv;
  logic        rd_start;
  logic        wr_start;

  function automatic logic [15:0] lanes(input logic [15:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0]  sel);
    lanes = old;
    if (sel[0]) begin
      lanes[7:0] = d[7:0];
    end
    if (sel[1]) begin
      lanes[15:8] = d[15:8];
    end
  endfunction

  dtpal_axis u_h (
    .clk        (clk),
    .rstn       (rstn),
    .adv        (1'b1),
    .total      (st_q.width),
    .sync_start (st_q.hs[7:0]),
    .sync_width (st_q.hs[15:8]),
    .act_off    (st_q.act[7:0]),
    .show_off   (st_q.bl[7:0]),
    .pos        (h_pos),
    .wrap       (h_wrap),
    .sync       (h_sync),
    .fetch      (h_fetch),
    .shown      (h_show)
  );

  dtpal_axis u_v (
    .clk        (clk),
    .rstn       (rstn),
    .adv        (h_wrap),
    .total      (st_q.height),
    .sync_start (st_q.vs[7:0]),
    .sync_width (st_q.vs[15:8]),
    .act_off    (st_q.act[15:8]),
    .show_off   (st_q.bl[15:8]),
    .pos        (v_pos),
    .wrap       (),
    .sync       (v_sync),
    .fetch      (v_fetch),
    .shown      (v_show)
  );

  dtpal_mem u_mem (
    .clk   (clk),
    .rstn  (rstn),
    .we    (mem_we),
    .waddr (st_q.op_addr),
    .wdata (st_q.op_data),
    .raddr (mem_raddr),
    .rdata (mem_rd)
  );

  // Bus decode and register read view
  always_comb begin
    acc    = wb_req.cyc && wb_req.stb && !st_q.ack;
    wr_acc = acc && wb_req.we;
    adr    = {wb_req.adr[5:2], 2'b00};
    case (adr)
      OFS_HEIGHT: rdv = {5'h00, st_q.height};
      OFS_ACT:    rdv = st_q.act;
      OFS_HSYNC:  rdv = st_q.hs;
      OFS_VSYNC:  rdv = st_q.vs;
      OFS_BLANK:  rdv = st_q.bl;
      OFS_PCTL:   rdv = {st_q.pal_en, st_q.busy, 4'h0,
                         st_q.trig, st_q.host, st_q.paddr};
      OFS_WDATA:  rdv = st_q.wr;
      OFS_RDATA:  rdv = st_q.rd;
      OFS_WIDTH:  rdv = {5'h00, st_q.width};
      OFS_CFG:    rdv = st_q.cfg;
      default:    rdv = 16'h0000;
    endcase
    nv = lanes(rdv, wb_req.dat, wb_req.sel);
    // Read starts only on a rising trigger with host access on
    rd_start = wr_acc && (adr == OFS_PCTL) && nv[PC_TRIG] &&
               !st_q.trig && nv[PC_HOST] && !st_q.busy;
    wr_start = wr_acc && (adr == OFS_WDATA) && wb_req.sel[1] &&
               !st_q.busy;
    mem_raddr = (st_q.busy && !st_q.op_wr) ? st_q.op_addr : pix_in[7:0];
    mem_we    = st_q.busy && st_q.op_wr && (st_q.cnt == 2'h0);
  end

  always_comb begin
    st_d     = st_q;
    st_d.ack = acc;
    st_d.dat = (acc && !wb_req.we) ? {16'h0000, rdv} : 32'h0000_0000;
    if (wr_acc) begin
      case (adr)
        OFS_HEIGHT: st_d.height = nv[10:0];
        OFS_ACT:    st_d.act = nv;
        OFS_HSYNC:  st_d.hs = nv;
        OFS_VSYNC:  st_d.vs = nv;
        OFS_BLANK:  st_d.bl = nv;
        OFS_PCTL: begin
          st_d.pal_en = nv[PC_EN];
          st_d.trig   = nv[PC_TRIG];
          st_d.host   = nv[PC_HOST];
          st_d.paddr  = nv[7:0];
        end
        OFS_WDATA:  st_d.wr = nv;
        OFS_WIDTH:  st_d.width = nv[10:0];
        OFS_CFG:    st_d.cfg = nv & CFG_MASK;
        default: begin
        end
      endcase
    end
    // Table access sequencing
    if (st_q.busy) begin
      if (st_q.cnt == 2'h0) begin
        st_d.busy = 1'b0;
        if (!st_q.op_wr) begin
          st_d.rd = mem_rd;
        end
      end else begin
        st_d.cnt = st_q.cnt - 2'h1;
      end
    end
    if (rd_start || wr_start) begin
      st_d.busy    = 1'b1;
      st_d.op_wr   = wr_start;
      st_d.cnt     = PAL_BUSY_CYC - 2'h1;
      st_d.op_addr = rd_start ? nv[7:0] : st_q.paddr;
      st_d.op_data = nv;
    end
    // Panel power follows its request after a delay of wr clocks
    if (wr_acc && (adr == OFS_CFG) && (nv[CF_PWR] != st_q.cfg[CF_PWR])) begin
      st_d.pwr_cnt = st_q.wr;
    end else if (st_q.pwr_cnt != 16'h0000) begin
      st_d.pwr_cnt = st_q.pwr_cnt - 16'h0001;
    end else begin
      st_d.vid.power = st_q.cfg[CF_PWR];
    end
    // Display pipeline, three stages behind the counters, pixel request one stage
    st_d.show = {st_q.show[0], h_show && v_show};
    st_d.hs_p = {st_q.hs_p[0], h_sync && st_q.cfg[CF_HSOE]};
    st_d.vs_p = {st_q.vs_p[0], v_sync && st_q.cfg[CF_VSOE]};
    st_d.raw1 = pix_in;
    st_d.vid.hsync   = st_q.hs_p[1];
    st_d.vid.vsync   = st_q.vs_p[1];
    st_d.vid.de      = st_q.show[1];
    st_d.vid.pix_req = h_fetch && v_fetch;
    if (!st_q.show[1]) begin
      st_d.vid.pixel = 16'h0000;
    end else if (!st_q.pal_en) begin
      st_d.vid.pixel = st_q.raw1;
    end else if (st_q.host) begin
      st_d.vid.pixel = 16'h0000;
    end else begin
      st_d.vid.pixel = mem_rd;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign wb_rsp = '{ack: st_q.ack, dat: st_q.dat};
  assign vid    = st_q.vid;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_trig_rise;
    wr_acc && (adr == OFS_PCTL) && wb_req.sel[1] && wb_req.dat[PC_TRIG] &&
      !st_q.trig && !st_q.busy;
  endsequence

  sequence s_busy_run;
    st_q.busy [*2] ##1 !st_q.busy;
  endsequence

  property p_height_rd;
    acc && !wb_req.we && (adr == OFS_HEIGHT) |=>
      wb_rsp.ack && (wb_rsp.dat[31:11] == 21'h000000);
  endproperty
  a_height_rd: assert property (p_height_rd)
    else $error("height upper bits not zero");

  property p_rd_busy;
    s_trig_rise ##0 wb_req.dat[PC_HOST] |=> s_busy_run;
  endproperty
  a_rd_busy: assert property (p_rd_busy)
    else $error("read access busy window wrong");

  property p_rd_gated;
    s_trig_rise ##0 !wb_req.dat[PC_HOST] |=> (!st_q.busy) [*2];
  endproperty
  a_rd_gated: assert property (p_rd_gated)
    else $error("read started without host access");

  property p_wr_start;
    wr_acc && (adr == OFS_WDATA) && wb_req.sel[1] && !st_q.busy |=>
      st_q.op_wr ##0 s_busy_run;
  endproperty
  a_wr_start: assert property (p_wr_start)
    else $error("table write not started");

  property p_lowbyte;
    wr_acc && (adr == OFS_WDATA) && (wb_req.sel[1:0] == 2'b01) &&
      !st_q.busy |=> !st_q.busy &&
      (st_q.wr[7:0] == $past(wb_req.dat[7:0]));
  endproperty
  a_lowbyte: assert property (p_lowbyte)
    else $error("low byte write misbehaved");

  property p_hs_oe;
    !st_q.cfg[CF_HSOE] |-> ##3 !vid.hsync;
  endproperty
  a_hs_oe: assert property (p_hs_oe)
    else $error("hsync toggled while disabled");

  property p_vs_oe;
    !st_q.cfg[CF_VSOE] |-> ##3 !vid.vsync;
  endproperty
  a_vs_oe: assert property (p_vs_oe)
    else $error("vsync toggled while disabled");

  property p_bypass;
    !st_q.pal_en && st_q.show[1] |=> vid.pixel == $past(pix_in, 2);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("bypass pixel mismatch");

  property p_bar;
    st_q.host && st_q.pal_en |=> vid.pixel == 16'h0000;
  endproperty
  a_bar: assert property (p_bar)
    else $error("display read table under host access");

  property p_pwr;
    $changed(st_q.cfg[CF_PWR]) |-> st_q.pwr_cnt == $past(st_q.wr);
  endproperty
  a_pwr: assert property (p_pwr)
    else $error("power delay not taken from write data");

  property p_rd_addr;
    rd_start && wb_req.sel[0] |=> st_q.op_addr == $past(wb_req.dat[7:0]);
  endproperty
  a_rd_addr: assert property (p_rd_addr)
    else $error("table read not at written address");

  property p_pix_req;
    h_fetch && v_fetch |=> vid.pix_req;
  endproperty
  a_pix_req: assert property (p_pix_req)
    else $error("pixel fetch window missing");

  property p_de;
    h_show && v_show |-> ##3 vid.de;
  endproperty
  a_de: assert property (p_de)
    else $error("display enable missing in shown area");

endmodule

// ==== dv/dtpal_panel.sv ====
// Panel model measuring sync, enable and pixel timing
`timescale 1ns/1ps
module dtpal_panel (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rstn,
  // Video from the block
  input  wire dtpal_pkg::dtpal_vid_s vid,
  // Measured figures in clocks or lines
  output int                         hs_per,
  output int                         hs_wid,
  output int                         hs_de,
  output int                         de_len,
  output int                         rq_de,
  output int                         vs_wid,
  output int                         vs_de,
  output int                         de_lines,
  output int                         hs_cnt,
  output int                         vs_cnt,
  output logic [15:0]                pix
);
  import dtpal_pkg::*;
  int         t;
  int         hs_t;
  int         de_t;
  int         rq_t;
  int         vs_t;
  int         lines;
  dtpal_vid_s p_q;

  // Edge times of each signal, taken as a real panel would see them
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      t <= 0;
      p_q <= '0;
      hs_cnt <= 0;
      vs_cnt <= 0;
      lines <= 0;
      pix <= 16'h0000;
    end else begin
      t <= t + 1;
      p_q <= vid;
      if (vid.hsync && !p_q.hsync) begin
        hs_per <= t - hs_t;
        hs_t <= t;
        hs_cnt <= hs_cnt + 1;
      end
      if (!vid.hsync && p_q.hsync) hs_wid <= t - hs_t;
      if (vid.de && !p_q.de) begin
        hs_de <= t - hs_t;
        de_t <= t;
        rq_de <= t - rq_t;
        lines <= lines + 1;
        if (lines == 0) vs_de <= t - vs_t;
      end
      if (!vid.de && p_q.de) de_len <= t - de_t;
      if (vid.pix_req && !p_q.pix_req) rq_t <= t;
      if (vid.de) pix <= vid.pixel;
      if (vid.vsync && !p_q.vsync) begin
        vs_t <= t;
        vs_cnt <= vs_cnt + 1;
        de_lines <= lines;
        lines <= 0;
      end
      if (!vid.vsync && p_q.vsync) vs_wid <= t - vs_t;
    end
  end
endmodule

// ==== dv/tb_top.sv ====
// Self-checking bench for the display timing and palette block
`timescale 1ns/1ps
module tb_top;
  import dtpal_pkg::*;
  logic          clk = 1'b0;
  logic          rstn = 1'b0;
  dtpal_wb_req_s wb_req = '0;
  dtpal_wb_rsp_s wb_rsp;
  logic [15:0]   pix_in = 16'h0004;
  dtpal_vid_s    vid;
  int            error_cnt = 0;
  int            checks_done = 0;
  int            hs_per, hs_wid, hs_de, de_len, vs_wid, vs_de;
  int            de_lines, hs_cnt, vs_cnt, n, m, rq_de;
  logic [15:0]   pix;
  logic [31:0]   q;

  always #12.5 clk = ~clk;

  dtpal_top dut (.clk(clk), .rstn(rstn), .wb_req(wb_req),
    .wb_rsp(wb_rsp), .pix_in(pix_in), .vid(vid));
  dtpal_panel panel (.clk(clk), .rstn(rstn), .vid(vid),
    .hs_per(hs_per), .hs_wid(hs_wid), .hs_de(hs_de), .de_len(de_len),
    .vs_wid(vs_wid), .vs_de(vs_de), .de_lines(de_lines),
    .hs_cnt(hs_cnt), .vs_cnt(vs_cnt), .rq_de(rq_de), .pix(pix));

  task wrap_up;
    if (error_cnt == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One classic cycle, held until ack is sampled
  task bus(input logic we, input logic [5:0] a, input logic [3:0] s,
           input logic [15:0] d);
    int k;
    @(posedge clk);
    wb_req <= '{1'b1, 1'b1, we, a, s, {16'h0000, d}};
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (wb_rsp.ack !== 1'b1 && k < 20);
    q = wb_rsp.dat;
    wb_req <= '0;
    if (k >= 20) begin
      error_cnt++;
      wrap_up();
    end
  endtask

  task wr(input logic [5:0] a, input logic [3:0] s, input logic [15:0] d);
    bus(1'b1, a, s, d);
  endtask

  task rdchk(input logic [5:0] a, input logic [15:0] e);
    bus(1'b0, a, 4'h3, 16'h0000);
    chk(q, {16'h0000, e});
  endtask

  task idle(input int c);
    repeat (c) @(posedge clk);
  endtask

  task wait_idle;
    n = 0;
    do begin
      bus(1'b0, OFS_PCTL, 4'h3, 16'h0000);
      n++;
    end while (q[PC_BUSY] !== 1'b0 && n < 10);
    chk(q & 32'h4000, 32'h0);
  endtask

  task t_regs;
    for (int i = 0; i <= 10; i++) rdchk(6'(i * 4), 16'h0000);
    wr(OFS_HEIGHT, 4'h3, 16'hffff);
    rdchk(OFS_HEIGHT, 16'h07ff);
    wr(OFS_WIDTH, 4'h3, 16'hffff);
    rdchk(OFS_WIDTH, 16'h07ff);
    wr(6'h28, 4'h3, 16'hffff);
    rdchk(6'h28, 16'h0000);
    wr(OFS_PCTL, 4'h3, 16'h7c00);
    rdchk(OFS_PCTL, 16'h0000);
  endtask

  task t_pal_write;
    for (int i = 0; i < 4; i++) begin
      wr(OFS_PCTL, 4'h3, 16'h0100 | 16'(i));
      wr(OFS_WDATA, 4'h3, 16'ha000 + 16'(i) * 16'h0111);
    end
    wr(OFS_PCTL, 4'h3, 16'h0104);
    wr(OFS_WDATA, 4'h2, 16'hbb00);
    wr(OFS_PCTL, 4'h3, 16'h0105);
    wr(OFS_WDATA, 4'h3, 16'h1234);
    wr(OFS_WDATA, 4'h1, 16'h0056);
    rdchk(OFS_WDATA, 16'h1256);
  endtask

  task t_pal_read;
    logic [7:0]  ra [3];
    logic [15:0] rv [3];
    ra = '{8'h00, 8'h04, 8'h05};
    rv = '{16'ha000, 16'hbb33, 16'h1234};
    for (int i = 0; i < 3; i++) begin
      wr(OFS_PCTL, 4'h3, {8'h03, ra[i]});
      wait_idle();
      rdchk(OFS_RDATA, rv[i]);
      wr(OFS_PCTL, 4'h3, {8'h01, ra[i]});
    end
    wr(OFS_PCTL, 4'h3, 16'h0002);
    wr(OFS_PCTL, 4'h3, 16'h0202);
    wait_idle();
    rdchk(OFS_RDATA, 16'h1234);
    wr(OFS_RDATA, 4'h3, 16'hffff);
    rdchk(OFS_RDATA, 16'h1234);
    wr(OFS_PCTL, 4'h3, 16'h0000);
  endtask

  // Width 40, height 12, frame of 480 clocks
  task t_timing;
    wr(OFS_HEIGHT, 4'h3, 16'h000c);
    wr(OFS_WIDTH, 4'h3, 16'h0028);
    wr(OFS_ACT, 4'h3, 16'h030a);
    wr(OFS_HSYNC, 4'h3, 16'h0304);
    wr(OFS_VSYNC, 4'h3, 16'h0201);
    wr(OFS_BLANK, 4'h3, 16'h030a);
    wr(OFS_CFG, 4'h3, 16'h0013);
    idle(1440);
    chk(hs_per, 40);
    chk(hs_wid, 3);
    chk(hs_de, 6);
    chk(de_len, 30);
    chk(rq_de, 2);
    chk(vs_wid, 80);
    chk(vs_de, 90);
    chk(de_lines, 9);
  endtask

  task t_gate;
    wr(OFS_CFG, 4'h3, 16'h0020);
    wr(OFS_ACT, 4'h3, 16'h000a);
    idle(480);
    n = hs_cnt;
    m = vs_cnt;
    idle(960);
    chk(hs_cnt, n);
    chk(vs_cnt, m);
    wr(OFS_ACT, 4'h3, 16'h030a);
    wr(OFS_CFG, 4'h3, 16'h0013);
    idle(960);
    chk(32'(hs_cnt > n), 32'h1);
    chk(32'(vs_cnt > m), 32'h1);
  endtask

  task t_pixel;
    wr(OFS_PCTL, 4'h3, 16'h8004);
    idle(480);
    chk(pix, 16'hbb33);
    wr(OFS_PCTL, 4'h3, 16'h8104);
    idle(480);
    chk(pix, 16'h0000);
    wr(OFS_PCTL, 4'h3, 16'h0004);
    // Moving pixels let the bypass alignment assertion bite
    repeat (120) @(posedge clk) pix_in <= pix_in + 16'h0001;
    @(posedge clk) pix_in <= 16'h0004;
    idle(480);
    chk(pix, 16'h0004);
  endtask

  task t_power;
    wr(OFS_WDATA, 4'h3, 16'h0014);
    wr(OFS_CFG, 4'h3, 16'h0017);
    n = 0;
    while (vid.power !== 1'b1 && n < 60) begin
      @(posedge clk);
      n++;
    end
    chk(32'(n >= 15 && n <= 24), 32'h1);
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_pal_write();
    t_pal_read();
    t_timing();
    t_gate();
    t_pixel();
    t_power();
    wrap_up();
  end
endmodule
